/* File: hdl/rcadc_top.sv */
// RC oscillation converter: two 24-bit counters, mode and control registers, pin drive.
// Contract
// - Two independent 24-bit counters plus mode and control registers.
// - Result comes from counting an oscillator whose rate follows the attached R or C.
// - Two oscillator channels share the counters; only one channel oscillates at a time.
// - Time-base low word register holds counter bits 15..0 at the first address.
// - Time-base upper register holds bits 23..16 in its low byte only.
// - Oscillation low word register holds counter bits 15..0.
// - Oscillation upper register holds bits 23..16 in its low byte only.
// - Software can preset and read back both counters.
// - While running, counter reads return the last written value.
// - When stopped, counter reads return the accumulated count.
// - All counter, mode and control registers reset to zero.
// - Word registers take byte and word access at even address, byte only at odd.
// - Per-channel input and drive pins, plus a shared oscillation monitor output.
// - Run bit starts and stops counting; any counter overflow clears it.
// - Time-base counts the base clock, oscillation counter the RC clock, to full scale.
// - Each counter has an overflow flag; a mode bit picks which raises the request.
// - Mode field picks one of eight oscillation setups over both circuits.
`timescale 1ns/10ps
module rcadc_top (
	// Clock, reset and enable.
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	// Register port.
	input wire rcadc_pkg::rcadc_bus_req_s bus_req,
	output logic [15:0] bus_rdata,
	// Clock sources from the clock generator.
	input wire logic lsclk_in,
	input wire logic osclk_in,
	// Oscillator pins.
	input wire logic channel0_osc_input,
	input wire logic channel1_osc_input,
	output rcadc_pkg::rcadc_drive_s pin_drive,
	output logic oscillation_monitor_output,
	output logic supply_range_select,
	// Interrupt.
	output logic converter_interrupt_request
);
	import rcadc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers: lsclk, osclk, channel 0, channel 1.
	// The first stage feeds only the second; edges are taken from stages two and three.
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] sync3_reg;
	wire [3:0] pin_async = {channel1_osc_input, channel0_osc_input, osclk_in, lsclk_in};
	wire [3:0] pin_rise = sync2_reg & ~sync3_reg;

	// Stage one is the only flop that may go metastable, so nothing else reads it.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sync1_reg <= 4'h0;
		end else if (clk_en) begin
			sync1_reg <= pin_async;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sync2_reg <= 4'h0;
		end else if (clk_en) begin
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sync3_reg <= 4'h0;
		end else if (clk_en) begin
			sync3_reg <= sync2_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register state.
	logic [15:0] mode_reg;
	logic run_reg;
	logic [RCADC_IRQ_W-1:0] status_reg;
	logic [RCADC_IRQ_W-1:0] mask_reg;
	logic [RCADC_PRESCALE_W-1:0] prescale_reg;
	logic [15:0] rdata_reg;
	logic irq_reg;
	logic monitor_reg;
	rcadc_drive_s drive_reg;
	logic [RCADC_CNT_W-1:0] cnt_reg [2];
	logic [RCADC_CNT_W-1:0] set_reg [2];

	////////////////////////////////////////////////////////////////////////////
	// Bus decode.
	// Byte and word lanes
	wire addr_odd = bus_req.addr[0];
	wire lo_en = bus_req.wr & ~addr_odd;
	// A byte write carries its data on the low lane, whichever byte it targets.
	wire hi_en = bus_req.wr & (addr_odd ? bus_req.byte_sel : ~bus_req.byte_sel);
	wire word_odd = ~bus_req.byte_sel & addr_odd;
	wire hit_tb_lo = bus_req.addr[15:1] == RCADC_ADDR_TB_LOW[15:1];
	wire hit_tb_hi = bus_req.addr[15:1] == RCADC_ADDR_TB_HIGH[15:1];
	wire hit_osc_lo = bus_req.addr[15:1] == RCADC_ADDR_OSC_LOW[15:1];
	wire hit_osc_hi = bus_req.addr[15:1] == RCADC_ADDR_OSC_HIGH[15:1];
	wire hit_mode = bus_req.addr[15:1] == RCADC_ADDR_MODE[15:1];
	wire hit_ctrl = bus_req.addr[15:1] == RCADC_ADDR_CTRL[15:1];
	wire hit_status = bus_req.addr[15:1] == RCADC_ADDR_STATUS[15:1];
	wire hit_mask = bus_req.addr[15:1] == RCADC_ADDR_MASK[15:1];

	wire [1:0] hit_cnt_lo = {hit_osc_lo, hit_tb_lo};
	wire [1:0] hit_cnt_hi = {hit_osc_hi, hit_tb_hi};

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
		input logic en_lo, input logic en_hi);
		logic [15:0] res;
		res = old;
		if (en_lo) begin
			res[7:0] = wd[7:0];
		end
		if (en_hi) begin
			res[15:8] = bus_req.byte_sel ? wd[7:0] : wd[15:8];
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Mode decode.
	wire [RCADC_MODE_OSC_W-1:0] osc_mode = mode_reg[RCADC_MODE_OSC_LSB +: RCADC_MODE_OSC_W];
	wire [RCADC_MODE_CLKSEL_W-1:0] clk_sel =
		mode_reg[RCADC_MODE_CLKSEL_LSB +: RCADC_MODE_CLKSEL_W];
	wire irq_sel = mode_reg[RCADC_MODE_IRQSEL_BIT];
	// Codes with the top bit set are prohibited; they stop the oscillator entirely.
	wire mode_legal = ~osc_mode[RCADC_MODE_OSC_W-1];
	// Channel choice
	// Channel 1 serves codes 5 to 7; prohibited codes never count, so their pick is moot.
	wire use_ch1 = osc_mode[2] & (osc_mode[1] | osc_mode[0]);
	wire osc_level = use_ch1 ? sync2_reg[3] : sync2_reg[2];
	wire osc_edge = use_ch1 ? pin_rise[3] : pin_rise[2];

	rcadc_drive_s drive_sel;
	always_comb begin
		drive_sel = RCADC_DRIVE_OFF;
		unique case (osc_mode)
			// External input modes leave every drive pin off.
			4'h0: begin
				drive_sel = RCADC_DRIVE_OFF;
			end
			4'h1: begin
				drive_sel.ch0_reference_resistor_pin = 1'b1;
				drive_sel.ch0_reference_cap_pin = 1'b1;
			end
			4'h2: begin
				drive_sel.ch0_resistive_sensor_pin = 1'b1;
				drive_sel.ch0_reference_cap_pin = 1'b1;
			end
			4'h3: begin
				drive_sel.ch0_resistive_sensor_pin = 1'b1;
				drive_sel.ch0_rc_sensor_pin = 1'b1;
				drive_sel.ch0_reference_cap_pin = 1'b1;
			end
			4'h4: begin
				drive_sel.ch0_reference_resistor_pin = 1'b1;
				drive_sel.ch0_rc_sensor_pin = 1'b1;
			end
			4'h5: begin
				drive_sel.ch1_reference_resistor_pin = 1'b1;
				drive_sel.ch1_reference_cap_pin = 1'b1;
			end
			4'h6: begin
				drive_sel.ch1_resistive_sensor_pin = 1'b1;
				drive_sel.ch1_reference_cap_pin = 1'b1;
			end
			4'h7: begin
				drive_sel = RCADC_DRIVE_OFF;
			end
			default: begin
				drive_sel = RCADC_DRIVE_OFF;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Count ticks.
	// Code 0 takes the low-speed clock; codes 1..7 divide the fast clock by 1..64.
	wire [RCADC_PRESCALE_W-1:0] div_mask =
		RCADC_PRESCALE_W'((7'h01 << (clk_sel - 3'h1)) - 7'h01);
	wire fast_tick = pin_rise[1] & ((prescale_reg & div_mask) == div_mask);
	wire base_tick = (clk_sel == 3'h0) ? pin_rise[0] : fast_tick;
	wire [1:0] cnt_tick = {run_reg & mode_legal & osc_edge, run_reg & base_tick};

	////////////////////////////////////////////////////////////////////////////
	// Counters: index 0 is the time base, index 1 the oscillation count.
	wire [1:0] cnt_ovf;
	wire [RCADC_CNT_W-1:0] cnt_view [2];
	generate
		for (genvar i = 0; i < 2; i++) begin : g_cnt
			// A write while running changes only the preset; the live count carries on.
			// Preset shown while running
			assign cnt_view[i] = run_reg ? set_reg[i] : cnt_reg[i];
			wire [15:0] lo_new = merge16(cnt_view[i][15:0], bus_req.wdata,
				lo_en & hit_cnt_lo[i], hi_en & hit_cnt_lo[i]);
			wire [7:0] hi_new = (lo_en & hit_cnt_hi[i]) ? bus_req.wdata[7:0]
				: cnt_view[i][23:16];
			wire wr_any = (lo_en | hi_en) & (hit_cnt_lo[i] | hit_cnt_hi[i]);
			wire [RCADC_CNT_W-1:0] written = {hi_new, lo_new};
			assign cnt_ovf[i] = cnt_tick[i] & (cnt_reg[i] == RCADC_CNT_MAX);
			wire [RCADC_CNT_W-1:0] cnt_next = (wr_any & ~run_reg) ? written
				: cnt_tick[i] ? cnt_reg[i] + 24'h000001 : cnt_reg[i];
			wire [RCADC_CNT_W-1:0] set_next = wr_any ? written : set_reg[i];

			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					cnt_reg[i] <= RCADC_CNT_RESET;
				end else if (clk_en) begin
					cnt_reg[i] <= cnt_next;
				end
			end

			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					set_reg[i] <= RCADC_CNT_RESET;
				end else if (clk_en) begin
					set_reg[i] <= set_next;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Control, status and mask.
	// Overflow ends the run over any write
	wire run_next = |cnt_ovf ? 1'b0
		: (lo_en & hit_ctrl) ? bus_req.wdata[RCADC_CTRL_RUN_BIT] : run_reg;
	// Bit 2 follows whichever overflow the mode bit picks, so one mask bit gates it.
	// Selected overflow raises the request
	wire [RCADC_IRQ_W-1:0] status_set = {irq_sel ? cnt_ovf[1] : cnt_ovf[0], cnt_ovf[1],
		cnt_ovf[0]};
	wire [RCADC_IRQ_W-1:0] status_clr = (lo_en & hit_status) ?
		bus_req.wdata[RCADC_IRQ_W-1:0] : RCADC_IRQ_RESET;
	// A flag raised in the same cycle as its clear stays set.
	wire [RCADC_IRQ_W-1:0] status_next = (status_reg & ~status_clr) | status_set;
	wire [15:0] mode_next = merge16(mode_reg, bus_req.wdata, lo_en & hit_mode,
		hi_en & hit_mode) & RCADC_MODE_WRITE_MASK;
	wire [RCADC_IRQ_W-1:0] mask_next = (lo_en & hit_mask) ?
		bus_req.wdata[RCADC_IRQ_W-1:0] : mask_reg;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_reg <= RCADC_REG_RESET;
		end else if (clk_en) begin
			mode_reg <= mode_next;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			run_reg <= 1'b0;
		end else if (clk_en) begin
			run_reg <= run_next;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			status_reg <= RCADC_IRQ_RESET;
		end else if (clk_en) begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mask_reg <= RCADC_IRQ_RESET;
		end else if (clk_en) begin
			mask_reg <= mask_next;
		end
	end

	// The prescaler restarts whenever the run stops so each conversion sees whole periods.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prescale_reg <= '0;
		end else if (clk_en) begin
			if (!run_reg) begin
				prescale_reg <= '0;
			end else if (pin_rise[1]) begin
				prescale_reg <= prescale_reg + 6'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path.
	// Stopped counters show the count
	wire [15:0] view_tb_lo = cnt_view[0][15:0];
	wire [15:0] view_tb_hi = {8'h00, cnt_view[0][23:16]};
	wire [15:0] view_osc_lo = cnt_view[1][15:0];
	wire [15:0] view_osc_hi = {8'h00, cnt_view[1][23:16]};
	wire [15:0] view_ctrl = {15'h0000, run_reg};
	wire [15:0] view_status = {13'h0000, status_reg};
	wire [15:0] view_mask = {13'h0000, mask_reg};
	wire [15:0] word_sel =
		hit_tb_lo ? view_tb_lo :
		hit_tb_hi ? view_tb_hi :
		hit_osc_lo ? view_osc_lo :
		hit_osc_hi ? view_osc_hi :
		hit_mode ? mode_reg :
		hit_ctrl ? view_ctrl :
		hit_status ? view_status :
		hit_mask ? view_mask : 16'h0000;
	wire [7:0] byte_pick = addr_odd ? word_sel[15:8] : word_sel[7:0];
	// Odd address serves only byte reads
	wire [15:0] rdata_next = ~bus_req.rd ? 16'h0000
		: word_odd ? 16'h0000
		: bus_req.byte_sel ? {8'h00, byte_pick}
		: word_sel;

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs.
	// Every output leaves a flip-flop, so its timing does not depend on decode depth.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= RCADC_REG_RESET;
		end else if (clk_en) begin
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_reg <= 1'b0;
		end else if (clk_en) begin
			irq_reg <= |(status_reg & mask_reg);
		end
	end

	// Oscillator runs only during a conversion
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			monitor_reg <= 1'b0;
		end else if (clk_en) begin
			monitor_reg <= run_reg & mode_legal & osc_level;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			drive_reg <= RCADC_DRIVE_OFF;
		end else if (clk_en) begin
			drive_reg <= run_reg ? drive_sel : RCADC_DRIVE_OFF;
		end
	end

	assign bus_rdata = rdata_reg;
	assign converter_interrupt_request = irq_reg;
	assign oscillation_monitor_output = monitor_reg;
	assign pin_drive = drive_reg;
	assign supply_range_select = mode_reg[RCADC_MODE_SUPPLY_BIT];

endmodule

/* File: pkg/rcadc_pkg.sv */
// Constants and carrier types for the RC oscillation converter counter block.
package rcadc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register addresses.
	localparam logic [15:0] RCADC_ADDR_TB_LOW = 16'hF800;
	localparam logic [15:0] RCADC_ADDR_TB_HIGH = 16'hF802;
	localparam logic [15:0] RCADC_ADDR_OSC_LOW = 16'hF804;
	localparam logic [15:0] RCADC_ADDR_OSC_HIGH = 16'hF806;
	localparam logic [15:0] RCADC_ADDR_MODE = 16'hF808;
	localparam logic [15:0] RCADC_ADDR_CTRL = 16'hF80A;
	localparam logic [15:0] RCADC_ADDR_STATUS = 16'hF80C;
	localparam logic [15:0] RCADC_ADDR_MASK = 16'hF80E;

	////////////////////////////////////////////////////////////////////////////
	// Field layouts.
	localparam int RCADC_CNT_W = 24;
	localparam int RCADC_MODE_OSC_LSB = 0;
	localparam int RCADC_MODE_OSC_W = 4;
	localparam int RCADC_MODE_IRQSEL_BIT = 4;
	localparam int RCADC_MODE_CLKSEL_LSB = 5;
	localparam int RCADC_MODE_CLKSEL_W = 3;
	localparam int RCADC_MODE_SUPPLY_BIT = 8;
	localparam int RCADC_CTRL_RUN_BIT = 0;
	localparam int RCADC_IRQ_W = 3;
	localparam int RCADC_ST_TB_OVF_BIT = 0;
	localparam int RCADC_ST_OSC_OVF_BIT = 1;
	localparam int RCADC_ST_REQ_BIT = 2;
	localparam int RCADC_PRESCALE_W = 6;
	localparam logic [15:0] RCADC_MODE_WRITE_MASK = 16'h01FF;
	localparam logic [15:0] RCADC_CTRL_WRITE_MASK = 16'h0001;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and limits.
	localparam logic [15:0] RCADC_REG_RESET = 16'h0000;
	localparam logic [23:0] RCADC_CNT_RESET = 24'h000000;
	localparam logic [23:0] RCADC_CNT_MAX = 24'hFFFFFF;
	localparam logic [2:0] RCADC_IRQ_RESET = 3'h0;

	////////////////////////////////////////////////////////////////////////////
	// Carriers.
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
		logic byte_sel;
	} rcadc_bus_req_s;

	typedef struct packed {
		logic ch1_resistive_sensor_pin;
		logic ch1_reference_resistor_pin;
		logic ch1_reference_cap_pin;
		logic ch0_resistive_sensor_pin;
		logic ch0_rc_sensor_pin;
		logic ch0_reference_resistor_pin;
		logic ch0_reference_cap_pin;
	} rcadc_drive_s;

	localparam rcadc_drive_s RCADC_DRIVE_OFF = 7'h00;

endpackage

/* File: tb/rcadc_osc_model.sv */
// Behavioural sensor networks and clock sources facing the converter pins.
`timescale 1ns/10ps
module rcadc_osc_model (
	// Clock and pin drive from the converter.
	input wire logic clk_sys,
	input wire rcadc_pkg::rcadc_drive_s pin_drive,
	// Clock and oscillator sources.
	output logic lsclk_in,
	output logic osclk_in,
	output logic channel0_osc_input,
	output logic channel1_osc_input
);
	import rcadc_pkg::*;
	logic [3:0] tick_reg = 4'h0;
	wire ch0_on = |pin_drive[3:0];
	wire ch1_on = |pin_drive[6:4];
	initial {lsclk_in, osclk_in, channel0_osc_input, channel1_osc_input} = 4'h0;
	// A network only oscillates while the converter drives it, so an idle input rests low.
	always @(posedge clk_sys) begin
		tick_reg <= tick_reg + 4'h1;
		osclk_in <= tick_reg[1];
		lsclk_in <= tick_reg[3];
		channel0_osc_input <= ch0_on & tick_reg[2];
		channel1_osc_input <= ch1_on & tick_reg[2];
	end
endmodule

/* File: tb/rcadc_top_checker.sv */
// Port-level assertions for the converter counter block, bound to its top.
`timescale 1ns/10ps
module rcadc_top_checker (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic resetn,
	// Register port.
	input wire rcadc_pkg::rcadc_bus_req_s bus_req,
	input wire logic [15:0] bus_rdata,
	// Pins and interrupt.
	input wire rcadc_pkg::rcadc_drive_s pin_drive,
	input wire logic supply_range_select,
	input wire logic converter_interrupt_request
);
	import rcadc_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire rd_word = bus_req.rd && !bus_req.byte_sel;
	wire wr_mode = bus_req.wr && !bus_req.byte_sel && bus_req.addr == RCADC_ADDR_MODE;
	wire rd_mode = rd_word && bus_req.addr == RCADC_ADDR_MODE;
	rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 16'h0000)
		else $error("read data not zero outside a read answer");
	odd_word_a: assert property (rd_word && bus_req.addr[0] |=> bus_rdata == 16'h0000)
		else $error("word read at odd address returned data");
	unused_byte_a: assert property (bus_req.rd && bus_req.byte_sel &&
		(bus_req.addr == 16'hF803 || bus_req.addr == 16'hF807) |=> bus_rdata == 16'h0000)
		else $error("unused counter byte not zero");
	upper_word_a: assert property (rd_word && (bus_req.addr == RCADC_ADDR_TB_HIGH ||
		bus_req.addr == RCADC_ADDR_OSC_HIGH) |=> bus_rdata[15:8] == 8'h00)
		else $error("upper counter word carries high byte");
	unmapped_read_a: assert property (bus_req.rd && bus_req.addr[15:4] != 12'hF80
		|=> bus_rdata == 16'h0000) else $error("unmapped read returned data");
	ctrl_reserved_a: assert property (rd_word && bus_req.addr == RCADC_ADDR_CTRL
		|=> bus_rdata[15:1] == 15'h0000) else $error("control reserved bits set");
	channel_excl_a: assert property (!(|pin_drive[6:4] && |pin_drive[3:0]))
		else $error("both channels driven at once");
	supply_follow_a: assert property (wr_mode |=> supply_range_select == $past(bus_req.wdata[8]))
		else $error("supply select does not follow mode write");
	mode_readback_a: assert property (wr_mode ##1 !bus_req.wr ##1 rd_mode
		|=> bus_rdata == ($past(bus_req.wdata, 3) & RCADC_MODE_WRITE_MASK))
		else $error("mode read back differs from write");
	irq_rise_c: cover property ($rose(converter_interrupt_request));
	ch1_drive_c: cover property (|pin_drive[6:4]);
	mode_back_c: cover property (wr_mode ##1 !bus_req.wr ##1 rd_mode);
endmodule
bind rcadc_top rcadc_top_checker chk (.clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .pin_drive(pin_drive), .supply_range_select(supply_range_select),
	.converter_interrupt_request(converter_interrupt_request));

/* File: tb/tb_rcadc_top.sv */
// Self-checking bench for the converter counter block.
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module tb_rcadc_top;
	import rcadc_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	rcadc_bus_req_s bus_req = '0;
	logic [15:0] bus_rdata;
	logic lsclk_in, osclk_in, ch0_in, ch1_in, mon, supply, irq;
	rcadc_drive_s pin_drive;
	int err_count = 0;
	int tests_run = 0;
	always #4 clk_sys = ~clk_sys;
	rcadc_top dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .lsclk_in(lsclk_in), .osclk_in(osclk_in),
		.channel0_osc_input(ch0_in), .channel1_osc_input(ch1_in), .pin_drive(pin_drive),
		.oscillation_monitor_output(mon), .supply_range_select(supply),
		.converter_interrupt_request(irq));
	rcadc_osc_model osc (.clk_sys(clk_sys), .pin_drive(pin_drive), .lsclk_in(lsclk_in),
		.osclk_in(osclk_in), .channel0_osc_input(ch0_in), .channel1_osc_input(ch1_in));
	////////////////////////////////////////////////////////////////////////////
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task bus_wr(input logic [15:0] a, input logic [15:0] d, input logic b);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, byte_sel: b};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task rd_chk(input logic [15:0] a, input logic b, input logic [15:0] exp);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1, byte_sel: b};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1 `CHK(bus_rdata, exp)
	endtask
	task set_counts(input logic [23:0] a, input logic [23:0] b);
		bus_wr(RCADC_ADDR_TB_LOW, a[15:0], 1'b0);
		bus_wr(RCADC_ADDR_TB_HIGH, {8'h00, a[23:16]}, 1'b0);
		bus_wr(RCADC_ADDR_OSC_LOW, b[15:0], 1'b0);
		bus_wr(RCADC_ADDR_OSC_HIGH, {8'h00, b[23:16]}, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task test_reset;
		for (int i = 0; i < 8; i++) rd_chk(16'hF800 + 16'(2 * i), 1'b0, 16'h0000);
		$display("reset values done");
	endtask
	task test_preset;
		bus_wr(RCADC_ADDR_TB_LOW, 16'hA55A, 1'b0);
		bus_wr(RCADC_ADDR_TB_HIGH, 16'hFFC3, 1'b0);
		bus_wr(16'hF803, 16'h0077, 1'b1);
		bus_wr(16'hF805, 16'h0096, 1'b1);
		bus_wr(RCADC_ADDR_OSC_HIGH, 16'h003C, 1'b1);
		bus_wr(16'hF801, 16'h1234, 1'b0);
		rd_chk(RCADC_ADDR_TB_LOW, 1'b0, 16'hA55A);
		rd_chk(RCADC_ADDR_TB_HIGH, 1'b0, 16'h00C3);
		rd_chk(16'hF803, 1'b1, 16'h0000);
		rd_chk(16'hF801, 1'b1, 16'h00A5);
		rd_chk(16'hF800, 1'b1, 16'h005A);
		rd_chk(RCADC_ADDR_OSC_LOW, 1'b0, 16'h9600);
		rd_chk(RCADC_ADDR_OSC_HIGH, 1'b0, 16'h003C);
		rd_chk(16'hF801, 1'b0, 16'h0000);
		rd_chk(16'hF810, 1'b0, 16'h0000);
		$display("preset and access sizes done");
	endtask
	task test_run(input logic [3:0] mode, input logic [6:0] drive);
		int n;
		set_counts(24'h000100, 24'h000200);
		bus_wr(RCADC_ADDR_MODE, {12'h010, mode}, 1'b0);
		rd_chk(RCADC_ADDR_MODE, 1'b0, {12'h010, mode});
		`CHK(supply, 1'b1)
		// Start on a fixed phase of the model's sources so that the counts are exact.
		for (n = 0; n < 16 && osc.tick_reg != 4'h0; n++) @(negedge clk_sys);
		if (n == 16) begin
			err_count++;
			$display("CHECK FAILED t=%0t source phase not found", $time);
			give_verdict;
		end
		bus_wr(RCADC_ADDR_CTRL, 16'h0001, 1'b0);
		repeat (200) @(posedge clk_sys);
		#1 `CHK(pin_drive, drive)
		`CHK(mon, 1'b1)
		rd_chk(RCADC_ADDR_TB_LOW, 1'b0, 16'h0100);
		rd_chk(RCADC_ADDR_OSC_LOW, 1'b0, 16'h0200);
		bus_wr(RCADC_ADDR_CTRL, 16'h0000, 1'b0);
		rd_chk(RCADC_ADDR_CTRL, 1'b0, 16'h0000);
		`CHK(pin_drive, 7'h00)
		`CHK(mon, 1'b0)
		rd_chk(RCADC_ADDR_TB_LOW, 1'b0, 16'h010D);
		rd_chk(RCADC_ADDR_OSC_LOW, 1'b0, 16'h021A);
		$display("run in mode %0d done", mode);
	endtask
	task test_ovf(input logic [15:0] mode, input logic [23:0] a, input logic [23:0] b,
		input logic [15:0] wrap_addr, input logic [2:0] st);
		int n;
		set_counts(a, b);
		bus_wr(RCADC_ADDR_MODE, mode, 1'b0);
		bus_wr(RCADC_ADDR_MASK, 16'h0004, 1'b0);
		bus_wr(RCADC_ADDR_CTRL, 16'h0001, 1'b0);
		for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk_sys);
		if (n == 2000) begin
			err_count++;
			$display("CHECK FAILED t=%0t interrupt never raised", $time);
			give_verdict;
		end
		`CHK(n > 40, 1'b1)
		rd_chk(RCADC_ADDR_CTRL, 1'b0, 16'h0000);
		rd_chk(RCADC_ADDR_STATUS, 1'b0, {13'h0000, st});
		rd_chk(wrap_addr, 1'b0, 16'h0000);
		bus_wr(RCADC_ADDR_MASK, 16'h0000, 1'b0);
		repeat (2) @(posedge clk_sys);
		#1 `CHK(irq, 1'b0)
		bus_wr(RCADC_ADDR_STATUS, 16'h0007, 1'b0);
		rd_chk(RCADC_ADDR_STATUS, 1'b0, 16'h0000);
		$display("overflow with mode %h done", mode);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		test_reset;
		test_preset;
		test_run(4'h1, 7'h03);
		test_run(4'h5, 7'h30);
		test_run(4'h3, 7'h0D);
		test_run(4'h4, 7'h06);
		test_run(4'h2, 7'h09);
		test_run(4'h6, 7'h50);
		test_ovf(16'h0021, 24'hFFFFF0, 24'h000000, RCADC_ADDR_TB_LOW, 3'h5);
		test_ovf(16'h0011, 24'h000000, 24'hFFFFF8, RCADC_ADDR_OSC_LOW, 3'h6);
		give_verdict;
	end
endmodule
